// >>> dacr_pkg.sv
// Package: register map, field layout and reset values of the converter configuration bank
package dacr_pkg;

    // ------------------------------------------------------------
    // Register indices (byte offset is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_Q_COMMON_MODE_RESISTOR = 8'h08;
    localparam logic [7:0] IDX_I_AUX_WORD_LOW = 8'h09;
    localparam logic [7:0] IDX_I_AUX_CONTROL = 8'h0a;
    localparam logic [7:0] IDX_Q_AUX_WORD_LOW = 8'h0b;
    localparam logic [7:0] IDX_Q_AUX_CONTROL = 8'h0c;
    localparam logic [7:0] IDX_REFERENCE_TRIM = 8'h0d;
    localparam logic [7:0] IDX_CALIBRATION_CONTROL = 8'h0e;
    localparam logic [7:0] IDX_CAL_START = 8'h12;
    localparam logic [7:0] IDX_CAL_STATUS = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CM_ENABLE_BIT = 7;
    localparam int CM_CODE_LSB = 0;
    localparam int AUX_EN_BIT = 7;
    localparam int AUX_SPAN_LSB = 5;
    localparam int AUX_TOP_LSB = 2;
    localparam int AUX_MSB_LSB = 0;
    localparam int PRELD_Q_BIT = 7;
    localparam int PRELD_I_BIT = 6;
    localparam int SEL_Q_BIT = 5;
    localparam int SEL_I_BIT = 4;
    localparam int CLK_GATE_BIT = 3;
    localparam int DIV_LSB = 0;
    localparam int START_BIT = 4;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [2:0] TOP_CODE_MAX = 3'h4;
    localparam logic [5:0] PRELOAD_FIXED = 6'h20;
    localparam logic [8:0] DIV_RATIO_MAX = 9'h100;
    localparam logic [31:0] PRDATA_UNMAPPED = 32'h0000_0000;

    typedef enum logic [1:0] {
        DACR_IDLE = 2'b01,
        DACR_RUN = 2'b10
    } dacr_state_t;

endpackage

// >>> dacr_config_regs.sv
// Module: APB configuration bank for auxiliary outputs, reference trim and calibration control
//
// Operation
// [RULE1] Q common-mode bit7 selects on-chip resistor
// [RULE2] Q common-mode resistor code in bits 5:0
// [RULE3] I aux word: low byte, two MSBs
// [RULE4] Aux words straight binary, reset zero
// [RULE5] I aux control bit7 enables output
// [RULE6] I aux span select bits 6:5
// [RULE7] I aux top select bits 4:2
// [RULE8] Q aux word: low byte, two MSBs
// [RULE9] Q aux control bit7 enables output
// [RULE10] Q aux span select bits 6:5
// [RULE11] Q aux top select bits 4:2
// [RULE12] Reference trim six-bit two's complement
// [RULE13] Preload source: fixed 32 or user
// [RULE14] Self-calibration channel selects, reset zero
// [RULE15] Bit3 gates the calibration clock
// [RULE16] Divider code 000 is 256, 001 128
// [RULE17] Calibration runs only on start bit
// [RULE18] Each divider code step halves ratio
// [RULE19] Unassigned bits read zero; reserved tops
`timescale 1ns/1ps
module dacr_config_regs #(
    parameter int CAL_RUN_CYCLES = 64
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Common-mode setting
    output logic q_cm_onchip_enable,
    output logic [5:0] q_cm_resistor_code,
    // Auxiliary converters
    output logic [9:0] i_aux_word,
    output logic i_aux_output_enable,
    output logic [1:0] i_aux_span_select,
    output logic [2:0] i_aux_top_select,
    output logic [9:0] q_aux_word,
    output logic q_aux_output_enable,
    output logic [1:0] q_aux_span_select,
    output logic [2:0] q_aux_top_select,
    // Reference
    output logic [5:0] reference_trim_code,
    // Calibration
    output logic q_preload_source,
    output logic i_preload_source,
    output logic q_selfcal_select,
    output logic i_selfcal_select,
    output logic cal_clock_gate,
    output logic [2:0] cal_clock_divider,
    output logic [8:0] cal_divide_ratio,
    output logic [5:0] q_preload_value,
    output logic [5:0] i_preload_value,
    output logic cal_busy,
    input wire logic [5:0] user_preload_value
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Straight halving: ratio = 256 >> code
    function automatic logic [8:0] div_ratio(input logic [2:0] code);
        div_ratio = dacr_pkg::DIV_RATIO_MAX >> code; // [RULE16] [RULE18]
    endfunction

    // Top-of-range codes above 100 are reserved; they are kept at the top code
    function automatic logic [2:0] clamp_top(input logic [2:0] code);
        clamp_top = (code > dacr_pkg::TOP_CODE_MAX) ? dacr_pkg::TOP_CODE_MAX : code; // [RULE19]
    endfunction

    function automatic logic [31:0] byte_addr(input logic [7:0] idx);
        byte_addr = {22'h00_0000, idx, 2'b00};
    endfunction

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] q_common_mode_resistor;
    logic [7:0] i_aux_word_low;
    logic [7:0] i_aux_control;
    logic [7:0] q_aux_word_low;
    logic [7:0] q_aux_control;
    logic [7:0] reference_trim;
    logic [7:0] calibration_control;
    dacr_pkg::dacr_state_t cal_state;
    logic [15:0] cal_count;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire wr_en = psel & penable & pwrite;
    wire hit_cm = paddr == byte_addr(dacr_pkg::IDX_Q_COMMON_MODE_RESISTOR);
    wire hit_iw = paddr == byte_addr(dacr_pkg::IDX_I_AUX_WORD_LOW);
    wire hit_ic = paddr == byte_addr(dacr_pkg::IDX_I_AUX_CONTROL);
    wire hit_qw = paddr == byte_addr(dacr_pkg::IDX_Q_AUX_WORD_LOW);
    wire hit_qc = paddr == byte_addr(dacr_pkg::IDX_Q_AUX_CONTROL);
    wire hit_rt = paddr == byte_addr(dacr_pkg::IDX_REFERENCE_TRIM);
    wire hit_cc = paddr == byte_addr(dacr_pkg::IDX_CALIBRATION_CONTROL);
    wire hit_st = paddr == byte_addr(dacr_pkg::IDX_CAL_START);
    wire hit_cs = paddr == byte_addr(dacr_pkg::IDX_CAL_STATUS);
    wire hit_any = hit_cm | hit_iw | hit_ic | hit_qw | hit_qc | hit_rt | hit_cc | hit_st | hit_cs;

    // Unassigned bits are masked off on write so they read back zero
    wire [7:0] wd = pwdata[7:0];
    wire [7:0] wd_cm = wd & 8'hbf; // [RULE19]
    wire [7:0] wd_rt = wd & 8'h3f; // [RULE19]
    wire start_req = wr_en & hit_st & wd[dacr_pkg::START_BIT];

    // Start with no channel selected or with the clock gated does nothing
    wire cal_go = start_req & cal_clock_gate & (q_selfcal_select | i_selfcal_select); // [RULE17]
    wire [15:0] run_last = 16'(CAL_RUN_CYCLES - 1);

    logic [7:0] rd_byte;
    assign rd_byte = hit_cm ? q_common_mode_resistor :
                     hit_iw ? i_aux_word_low :
                     hit_ic ? i_aux_control :
                     hit_qw ? q_aux_word_low :
                     hit_qc ? q_aux_control :
                     hit_rt ? reference_trim :
                     hit_cc ? calibration_control :
                     hit_cs ? {7'h00, cal_state == dacr_pkg::DACR_RUN} :
                     8'h00;

    // ------------------------------------------------------------
    // Field views
    // ------------------------------------------------------------
    wire [9:0] next_i_word = {i_aux_control[1:0], i_aux_word_low}; // [RULE3] [RULE4]
    wire [9:0] next_q_word = {q_aux_control[1:0], q_aux_word_low}; // [RULE8] [RULE4]
    wire [2:0] next_div = calibration_control[dacr_pkg::DIV_LSB +: 3];
    wire next_q_preld = calibration_control[dacr_pkg::PRELD_Q_BIT];
    wire next_i_preld = calibration_control[dacr_pkg::PRELD_I_BIT];

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // One strobe per register keeps each write block small
    wire wr_cm = wr_en & hit_cm;
    wire wr_iw = wr_en & hit_iw;
    wire wr_ic = wr_en & hit_ic;
    wire wr_qw = wr_en & hit_qw;
    wire wr_qc = wr_en & hit_qc;
    wire wr_rt = wr_en & hit_rt;
    wire wr_cc = wr_en & hit_cc;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q_common_mode_resistor <= dacr_pkg::RST_REG; // [RULE1] [RULE2]
        end else if (wr_cm) begin
            q_common_mode_resistor <= wd_cm;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            i_aux_word_low <= dacr_pkg::RST_REG;
        end else if (wr_iw) begin
            i_aux_word_low <= wd;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            i_aux_control <= dacr_pkg::RST_REG; // [RULE5] [RULE6] [RULE7]
        end else if (wr_ic) begin
            i_aux_control <= wd;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q_aux_word_low <= dacr_pkg::RST_REG;
        end else if (wr_qw) begin
            q_aux_word_low <= wd;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q_aux_control <= dacr_pkg::RST_REG; // [RULE9] [RULE10] [RULE11]
        end else if (wr_qc) begin
            q_aux_control <= wd;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reference_trim <= dacr_pkg::RST_REG; // [RULE12]
        end else if (wr_rt) begin
            reference_trim <= wd_rt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            calibration_control <= dacr_pkg::RST_REG; // [RULE14] [RULE15]
        end else if (wr_cc) begin
            calibration_control <= wd;
        end
    end

    // ------------------------------------------------------------
    // Calibration run window
    // ------------------------------------------------------------
    // Clearing the clock gate ends a run early: the sequencer has no clock then
    wire run_done = (cal_count == run_last) | ~cal_clock_gate;

    // Only marks the run; the sequencer itself lives elsewhere
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cal_state <= dacr_pkg::DACR_IDLE;
            cal_count <= 16'h0000;
        end else begin
            case (cal_state)
                dacr_pkg::DACR_IDLE: begin
                    cal_count <= 16'h0000;
                    if (cal_go) begin
                        cal_state <= dacr_pkg::DACR_RUN; // [RULE17]
                    end
                end
                dacr_pkg::DACR_RUN: begin
                    cal_count <= cal_count + 16'h0001;
                    if (run_done) begin
                        cal_state <= dacr_pkg::DACR_IDLE;
                    end
                end
                default: begin
                    cal_state <= dacr_pkg::DACR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Common-mode outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q_cm_onchip_enable <= 1'b0;
            q_cm_resistor_code <= 6'h00;
        end else begin
            q_cm_onchip_enable <= q_common_mode_resistor[dacr_pkg::CM_ENABLE_BIT]; // [RULE1]
            q_cm_resistor_code <= q_common_mode_resistor[dacr_pkg::CM_CODE_LSB +: 6]; // [RULE2]
        end
    end

    // ------------------------------------------------------------
    // I auxiliary outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            i_aux_word <= 10'h000;
            i_aux_output_enable <= 1'b0;
            i_aux_span_select <= 2'h0;
            i_aux_top_select <= 3'h0;
        end else begin
            i_aux_word <= next_i_word; // [RULE3]
            i_aux_output_enable <= i_aux_control[dacr_pkg::AUX_EN_BIT]; // [RULE5]
            i_aux_span_select <= i_aux_control[dacr_pkg::AUX_SPAN_LSB +: 2]; // [RULE6]
            i_aux_top_select <= clamp_top(i_aux_control[dacr_pkg::AUX_TOP_LSB +: 3]); // [RULE7]
        end
    end

    // ------------------------------------------------------------
    // Q auxiliary outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q_aux_word <= 10'h000;
            q_aux_output_enable <= 1'b0;
            q_aux_span_select <= 2'h0;
            q_aux_top_select <= 3'h0;
        end else begin
            q_aux_word <= next_q_word; // [RULE8]
            q_aux_output_enable <= q_aux_control[dacr_pkg::AUX_EN_BIT]; // [RULE9]
            q_aux_span_select <= q_aux_control[dacr_pkg::AUX_SPAN_LSB +: 2]; // [RULE10]
            q_aux_top_select <= clamp_top(q_aux_control[dacr_pkg::AUX_TOP_LSB +: 3]); // [RULE11]
        end
    end

    // ------------------------------------------------------------
    // Reference output
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reference_trim_code <= 6'h00;
        end else begin
            reference_trim_code <= reference_trim[5:0]; // [RULE12]
        end
    end

    // ------------------------------------------------------------
    // Calibration preload outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q_preload_source <= 1'b0;
            i_preload_source <= 1'b0;
            q_preload_value <= dacr_pkg::PRELOAD_FIXED;
            i_preload_value <= dacr_pkg::PRELOAD_FIXED;
        end else begin
            q_preload_source <= next_q_preld; // [RULE13]
            i_preload_source <= next_i_preld; // [RULE13]
            q_preload_value <= next_q_preld ? user_preload_value : dacr_pkg::PRELOAD_FIXED; // [RULE13]
            i_preload_value <= next_i_preld ? user_preload_value : dacr_pkg::PRELOAD_FIXED; // [RULE13]
        end
    end

    // ------------------------------------------------------------
    // Calibration selects and clock outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q_selfcal_select <= 1'b0;
            i_selfcal_select <= 1'b0;
            cal_clock_gate <= 1'b0;
            cal_clock_divider <= 3'h0;
            cal_divide_ratio <= dacr_pkg::DIV_RATIO_MAX;
        end else begin
            q_selfcal_select <= calibration_control[dacr_pkg::SEL_Q_BIT]; // [RULE14]
            i_selfcal_select <= calibration_control[dacr_pkg::SEL_I_BIT]; // [RULE14]
            cal_clock_gate <= calibration_control[dacr_pkg::CLK_GATE_BIT]; // [RULE15]
            cal_clock_divider <= next_div; // [RULE16]
            cal_divide_ratio <= div_ratio(next_div); // [RULE16] [RULE18]
        end
    end

    // ------------------------------------------------------------
    // Calibration busy output
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cal_busy <= 1'b0;
        end else begin
            cal_busy <= cal_state == dacr_pkg::DACR_RUN; // [RULE17]
        end
    end

    // ------------------------------------------------------------
    // APB answer: zero-wait, read data registered in the setup cycle
    // ------------------------------------------------------------
    // Registered outputs: answer one cycle after setup, in the access phase
    wire setup_phase = psel & ~penable;
    wire next_pslverr = setup_phase & ~hit_any;
    wire [31:0] next_prdata = (setup_phase & ~pwrite) ? {24'h00_0000, rd_byte} : dacr_pkg::PRDATA_UNMAPPED;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_phase;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= next_pslverr; // [RULE19]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prdata <= dacr_pkg::PRDATA_UNMAPPED;
        end else begin
            prdata <= next_prdata; // [RULE19]
        end
    end

endmodule

// >>> dacr_config_regs_assertions.sv
// Concurrent checks on the ports of the configuration bank
`timescale 1ns/1ps
module dacr_config_regs_assertions #(
    parameter int CAL_RUN_CYCLES = 64
) (
    // Clock, reset and bus
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Settings
    input wire logic [5:0] q_cm_resistor_code,
    input wire logic i_aux_output_enable,
    input wire logic [2:0] i_aux_top_select,
    input wire logic [2:0] q_aux_top_select,
    input wire logic [2:0] cal_clock_divider,
    input wire logic [8:0] cal_divide_ratio,
    input wire logic i_preload_source,
    input wire logic [5:0] i_preload_value,
    input wire logic cal_clock_gate,
    input wire logic q_selfcal_select,
    input wire logic i_selfcal_select,
    input wire logic cal_busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire mapped = paddr inside {32'h20, 32'h24, 32'h28, 32'h2c, 32'h30, 32'h34, 32'h38, 32'h48, 32'h80};
    wire wr = psel && penable && pwrite && pready;
    int busy_cnt;
    // Run length counted here, a repetition cannot take the parameter
    always_ff @(posedge sys_clk) busy_cnt <= (srst || !cal_busy) ? 0 : busy_cnt + 1;

    mapped_answer_a: assert property (psel && !penable && mapped |=> pready && !pslverr)
        else $error("mapped access not answered cleanly");
    unmapped_error_a: assert property (psel && !penable && !mapped |=> pready && pslverr)
        else $error("unmapped access without error");
    cm_code_write_a: assert property (wr && paddr == 32'h20 |=> ##1 q_cm_resistor_code == $past(pwdata[5:0], 2))
        else $error("common-mode code not taken from write");
    i_enable_write_a: assert property (wr && paddr == 32'h28 |=> ##1 i_aux_output_enable == $past(pwdata[7], 2))
        else $error("aux enable not taken from write");
    i_top_legal_a: assert property (i_aux_top_select <= 3'h4)
        else $error("i top select beyond last code");
    q_top_legal_a: assert property (q_aux_top_select <= 3'h4)
        else $error("q top select beyond last code");
    div_ratio_a: assert property (cal_divide_ratio == (9'h100 >> cal_clock_divider))
        else $error("divide ratio does not match divider code");
    fixed_preload_a: assert property (!i_preload_source && !$past(i_preload_source) |-> i_preload_value == 6'h20)
        else $error("fixed preload not 32");
    busy_start_a: assert property ($rose(cal_busy) |-> cal_clock_gate && (q_selfcal_select || i_selfcal_select))
        else $error("calibration ran without gate and select");
    busy_length_a: assert property (busy_cnt <= CAL_RUN_CYCLES)
        else $error("calibration ran too long");
endmodule

bind dacr_config_regs dacr_config_regs_assertions #(.CAL_RUN_CYCLES(CAL_RUN_CYCLES)) u_assert (.sys_clk, .srst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .q_cm_resistor_code, .i_aux_output_enable,
    .i_aux_top_select, .q_aux_top_select, .cal_clock_divider, .cal_divide_ratio, .i_preload_source,
    .i_preload_value, .cal_clock_gate, .q_selfcal_select, .i_selfcal_select, .cal_busy);

// >>> dacr_config_regs_tb_top.sv
// Self-checking testbench of the configuration bank
`timescale 1ns/1ps
module dacr_config_regs_tb_top;
    localparam int CAL = 4;
    logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic pready, pslverr, q_cm_onchip_enable, i_aux_output_enable, q_aux_output_enable, cal_busy;
    logic q_preload_source, i_preload_source, q_selfcal_select, i_selfcal_select, cal_clock_gate;
    logic [5:0] q_cm_resistor_code, reference_trim_code, q_preload_value, i_preload_value, user_preload_value = 0;
    logic [9:0] i_aux_word, q_aux_word;
    logic [1:0] i_aux_span_select, q_aux_span_select;
    logic [2:0] i_aux_top_select, q_aux_top_select, cal_clock_divider;
    logic [8:0] cal_divide_ratio;
    logic [7:0] sh [7];
    logic [7:0] mask [7] = '{8'hbf, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff};
    int miscompares = 0, n_tests = 0, cycles = 0, n;

    dacr_config_regs #(.CAL_RUN_CYCLES(CAL)) dut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .q_cm_onchip_enable, .q_cm_resistor_code, .i_aux_word, .i_aux_output_enable,
        .i_aux_span_select, .i_aux_top_select, .q_aux_word, .q_aux_output_enable, .q_aux_span_select,
        .q_aux_top_select, .reference_trim_code, .q_preload_source, .i_preload_source, .q_selfcal_select,
        .i_selfcal_select, .cal_clock_gate, .cal_clock_divider, .cal_divide_ratio, .q_preload_value,
        .i_preload_value, .cal_busy, .user_preload_value);

    initial forever #20 sys_clk = ~sys_clk;

    task automatic end_sim;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Hang guard
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; the extra leading edge keeps psel from being set twice in one step
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        // Wait states end when pready rises; a wait that never ends is stopped only by the hang guard
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    function automatic logic [31:0] ad(input int i);
        return 32'((8 + i) * 4);
    endfunction

    function automatic logic [2:0] top(input logic [2:0] t);
        return (t > 3'h4) ? 3'h4 : t;
    endfunction

    task automatic check_outs;
        repeat (2) @(posedge sys_clk);
        chk("cm_en", sh[0][7], q_cm_onchip_enable);
        chk("cm_code", sh[0][5:0], q_cm_resistor_code);
        chk("i_word", {sh[2][1:0], sh[1]}, i_aux_word);
        chk("i_en", sh[2][7], i_aux_output_enable);
        chk("i_span", sh[2][6:5], i_aux_span_select);
        chk("i_top", top(sh[2][4:2]), i_aux_top_select);
        chk("q_word", {sh[4][1:0], sh[3]}, q_aux_word);
        chk("q_en", sh[4][7], q_aux_output_enable);
        chk("q_span", sh[4][6:5], q_aux_span_select);
        chk("q_top", top(sh[4][4:2]), q_aux_top_select);
        chk("ref_trim", sh[5][5:0], reference_trim_code);
        chk("q_pre_val", sh[6][7] ? user_preload_value : 6'h20, q_preload_value);
        chk("i_pre_val", sh[6][6] ? user_preload_value : 6'h20, i_preload_value);
        chk("cal_ctl", sh[6], {q_preload_source, i_preload_source, q_selfcal_select, i_selfcal_select,
            cal_clock_gate, cal_clock_divider});
        chk("ratio", 9'h100 >> sh[6][2:0], cal_divide_ratio);
    endtask

    task automatic wr_reg(input int i, input logic [31:0] d);
        xfer(1, ad(i), d);
        sh[i] = d[7:0] & mask[i];
        xfer(0, ad(i), 0);
        chk("readback", {24'h0, sh[i]}, rd);
        chk("slverr", 0, err);
        check_outs();
    endtask

    task automatic check_reset;
        for (int i = 0; i < 7; i++) begin
            sh[i] = 8'h00;
            xfer(0, ad(i), 0);
            chk("reset_value", 0, rd);
        end
        check_outs();
    endtask

    initial begin
        void'($urandom(32'ha042));
        @(posedge sys_clk);
        // Low bit forced so a user preload never looks like the fixed 32
        user_preload_value <= 6'($urandom) | 6'h01;
        repeat (3) @(posedge sys_clk);
        srst <= 0;
        check_reset();
        wr_reg(0, 32'hffff_ffff);
        wr_reg(5, 32'hffff_ffff);
        wr_reg(2, 32'h1c);
        wr_reg(1, 32'hff);
        wr_reg(2, 32'h03);
        wr_reg(1, 32'h00);
        wr_reg(2, 32'h02);
        for (int k = 0; k < 8; k++) wr_reg(6, k * 32'h41);
        repeat (30) wr_reg($urandom % 7, $urandom);
        // Unmapped word between the bank and the start register
        xfer(1, 32'h3c, 32'hff);
        xfer(0, 32'h3c, 0);
        chk("unmapped_err", 1, err);
        chk("unmapped_data", 0, rd);
        wr_reg(6, 32'h18);
        xfer(1, 32'h48, 32'h10);
        n = 0;
        while (cal_busy !== 1'b1 && n < 10) begin
            @(posedge sys_clk);
            n++;
        end
        chk("busy_rise", 1, cal_busy);
        n = 0;
        while (cal_busy === 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        chk("busy_len", CAL, n);
        xfer(1, 32'h48, 32'h10);
        xfer(0, 32'h80, 0);
        chk("busy_status", 1, rd);
        repeat (CAL + 2) @(posedge sys_clk);
        xfer(0, 32'h80, 0);
        chk("idle_status", 0, rd);
        wr_reg(6, 32'h30);
        xfer(1, 32'h48, 32'h10);
        n = 0;
        repeat (12) begin
            @(posedge sys_clk);
            if (cal_busy !== 1'b0) n++;
        end
        chk("no_gate_busy", 0, n);
        // Second reset with registers 0 to 5 written to all ones and calibration control left at 0x30
        for (int i = 0; i < 6; i++) wr_reg(i, 32'hffff_ffff);
        @(posedge sys_clk);
        srst <= 1;
        repeat (2) @(posedge sys_clk);
        srst <= 0;
        check_reset();
        end_sim();
    end
endmodule
